/* dv/aas_autopeak_asserts.sv */
// Purpose: Port checks for the autopeak sequencer
// Assumes: One clock, synchronous active high reset
// Notes: A stop is a taken control write with bit 1 set in lane 0
module aas_autopeak_asserts (
	input wire logic	clk,
	input wire logic	reset,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [7:0]	wb_adr_i,
	input wire logic [31:0]	wb_dat_i,
	input wire logic [3:0]	wb_sel_i,
	input wire logic [31:0]	wb_dat_o,
	input wire logic	wb_ack_o,
	input wire logic	azCw,
	input wire logic	azCcw,
	input wire logic	elUp,
	input wire logic	elDn,
	input wire logic	polCw,
	input wire logic	polCcw,
	input wire aas_pkg::aas_disp_t	line4
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	wire logic moving = azCw | azCcw | elUp | elDn | polCw | polCcw;
	sequence taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence stopReq;
		taken ##0 wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && wb_dat_i[1];
	endsequence
	bus_ack_a: assert property (taken |=> wb_ack_o) else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
	stop_halt_a: assert property (stopReq |-> ##3 !moving [*4]) else $error("moving after stop");
	scan_count_a: assert property (line4.msg == aas_pkg::MSG_SCAN |-> line4.step <= line4.total)
		else $error("step past total");
	fine_counts_a: assert property (line4.msg == aas_pkg::MSG_PEAKUP |-> line4.showCounts)
		else $error("angles during peakup");
	tilt_elhold_a: assert property (line4.msg == aas_pkg::MSG_TILT |-> !elUp && !elDn)
		else $error("elevation moved in tilt");
	spiral_turn_a: assert property (line4.msg == aas_pkg::MSG_SPIRAL && $past(line4.msg) == aas_pkg::MSG_SPIRAL
		&& $changed(line4.dir) |-> 2'(line4.dir - $past(line4.dir)) == 2'h1)
		else $error("spiral out of order");
	reset_idle_a: assert property (disable iff (1'b0) reset |=> !moving && line4.msg == aas_pkg::MSG_IDLE)
		else $error("not idle after reset");
endmodule // aas_autopeak_asserts
bind aas_autopeak aas_autopeak_asserts u_chk (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .azCw, .azCcw, .elUp, .elDn, .polCw, .polCcw, .line4);

/* dv/aas_autopeak_bench.sv */
// Purpose: Self-checking bench for the autopeak sequencer
// Assumes: Settle wait shortened to 4 cycles
// Notes: Motion results are judged inside a small position band
module aas_autopeak_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, req = 0, wen = 0, hiRes = 1, findable = 0, ack;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rdat, seed = 32'h5987;
	logic [11:0] noise = 12'h100, sig;
	logic signed [15:0] az, el, pol, roll = 0;
	logic azCw, azCcw, elUp, elDn, polCw, polCcw;
	aas_pkg::aas_disp_t line4;
	int failures = 0, comparisons = 0, azMin = 0, total = 0, step;
	// Pots read off by 300 so only pulse feedback can close the moves
	aas_autopeak #(.SETTLE_CYC(4)) u_dut (.clk, .reset, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(wen),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
		.azPotIn(az + 16'sd300), .azPulseIn(az), .elPotIn(el - 16'sd300), .elPulseIn(el), .polPosIn(pol),
		.hiResIn(hiRes), .sigIn(sig), .pitchIn(seed[15:0]), .rollIn(roll), .azCw, .azCcw, .elUp, .elDn,
		.polCw, .polCcw, .line4);
	aas_plant u_plant (.clk, .azCw, .azCcw, .elUp, .elDn, .polCw, .polCcw, .noise, .findable, .az, .el,
		.pol, .sig);
	initial forever #2.5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic near(input int a, input int b, input int t);
		return a - b <= t && b - a <= t;
	endfunction
	always @(posedge clk)
	begin
		seed <= xs(seed);
		noise <= {4'h1, seed[7:0]};
		if (line4.msg == aas_pkg::MSG_SCAN) total <= int'(line4.total);
		if (az < azMin) azMin <= az;
	end
	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ok(input logic c);
		check(32'(c), 32'h1);
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1;
		wen <= we;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (!ack && ++n < 20);
		q = rdat;
		req <= 0;
		if (n >= 20)
		begin
			failures++;
			results();
		end
	endtask
	// Start a sequence and poll status until the jog state returns
	task automatic go(input logic [31:0] ctl, output logic [31:0] s);
		int n;
		n = 0;
		bus(1, 8'h00, ctl, s);
		repeat (3) bus(0, 8'h20, 0, s);
		do bus(0, 8'h20, 0, s); while (!s[6] && ++n < 9000);
		if (n >= 9000)
		begin
			failures++;
			results();
		end
	endtask
	initial
	begin
		logic [31:0] q;
		repeat (5) @(posedge clk);
		reset <= 0;
		for (int i = 0; i < aas_pkg::NUM_CFG; i++)
		begin
			bus(0, 8'(4 * i), 0, q);
			check(q, aas_pkg::RST_CFG[i]);
		end
		bus(0, 8'h30, 0, q);
		check(q, 0);
		$display("registers done");
		bus(1, 8'h04, 10, q);
		bus(1, 8'h10, 50, q);
		bus(0, 8'h10, 0, q);
		check(q, 50);
		step = int'(aas_pkg::BEAM_NUM[1]) / 10 / 2;
		findable <= 1;
		go(32'h55, q);
		ok(q[7]);
		check(total, 100 / step);
		ok(near(azMin, -40, 3));
		ok(near(az, 20, step));
		check({azCw, azCcw, elUp, elDn}, 0);
		$display("scan done");
		findable <= 0;
		go(32'h4d, q);
		ok(!q[7]);
		ok(near(az, 10, 2) && near(el, 400, 2));
		findable <= 1;
		go(32'h4d, q);
		ok(q[7]);
		ok(near(az, 20, 6) && near(el, 400, 6));
		bus(0, 8'h28, 0, q);
		check(q, {16'sd400, 16'(10 + step)});
		$display("spiral done");
		roll <= $signed(seed[6:0]);
		go(32'h61, q);
		ok(q[5]);
		ok(near(pol, -roll, 2));
		ok(near(az, 10, 2) && near(el, 400, 2));
		bus(0, 8'h2c, 0, q);
		check(q[31:16], roll[15:0]);
		$display("tilt done");
		bus(1, 8'h00, 32'h45, q);
		repeat (20) bus(0, 8'h20, 0, q);
		bus(1, 8'h00, 32'h02, q);
		bus(0, 8'h20, 0, q);
		ok(q[6]);
		check({azCw, azCcw, elUp, elDn, polCw, polCcw}, 0);
		$display("stop done");
		results();
	end
endmodule // aas_autopeak_bench

/* dv/aas_plant.sv */
// Purpose: Behavioural mount with drives, sensors and one signal spot
// Assumes: Clockwise and up raise the readings
// Notes: One unit per four clocks keeps overshoot inside the tolerance
module aas_plant #(
	parameter int PK_AZ = 20,
	parameter int PK_EL = 400
) (
	input wire logic	clk,
	input wire logic	azCw,
	input wire logic	azCcw,
	input wire logic	elUp,
	input wire logic	elDn,
	input wire logic	polCw,
	input wire logic	polCcw,
	input wire logic [11:0]	noise,
	input wire logic	findable,
	output logic signed [15:0]	az,
	output logic signed [15:0]	el,
	output logic signed [15:0]	pol,
	output logic [11:0]	sig
);
	logic [1:0] div = 2'h0;
	logic signed [15:0] azP = 16'sh0, elP = 16'sh0190, polP = 16'sh0;
	always @(posedge clk)
	begin
		div <= div + 2'h1;
		if (div == 2'h0)
		begin
			azP <= azP + 16'(azCw) - 16'(azCcw);
			elP <= elP + 16'(elUp) - 16'(elDn);
			polP <= polP + 16'(polCw) - 16'(polCcw);
		end
	end
	assign az = azP;
	assign el = elP;
	assign pol = polP;
	assign sig = findable && (azP - PK_AZ) * (azP - PK_AZ) <= 36 && (elP - PK_EL) * (elP - PK_EL) <= 36
		? 12'hc00 : noise;
endmodule // aas_plant

/* verilog/aas_autopeak.sv */
// Purpose: Autopeak sequencer finishing an automatic pointing operation
// Assumes: Classic Wishbone slave, one clock, sensor pins asynchronous
// Notes:   Every axis move is followed by a settle wait before sampling
//
// Contract
// - Sweep starts at the range-offset point nearer the current azimuth.
// - Sample after each step; feed noise average and peak detection.
// - Step size follows antenna diameter and band beam width.
// - Elevation is corrected every few sweep steps.
// - Sweep ends early when the next step passes the azimuth limit.
// - After sweep go to best peak, else back to target azimuth.
// - Display shows total planned steps and current step in sweep.
// - Sweep range is a register writable at any time.
// - Completion leaves the sequencer in operator jog state.
// - Spiral first drives to target, corrects elevation, takes one sample.
// - Spiral steps CW, up, CCW, down with growing leg lengths.
// - Spiral stops once a sample exceeds the threshold.
// - Spiral without a find returns to the target position.
// - Display shows spiral direction and step number.
// - Pulse-count feedback closes moves when available.
// - Fine peak-up needs high resolution sensors and enable bit.
// - Fine peak-up jogs around sweep peak; display shows counts.
// - Fine jog size approximates a 0.3 dB signal change.
// - Tilt mode visits points 90 and 45 degrees off, elevation held.
// - Tilt mode adds a polarization correction move at the end.
// - Peaking runs sweep when not inclined, spiral when inclined.
// - Stop halts all motion and enters the jog state.
module aas_autopeak #(
	parameter int SETTLE_CYC = aas_pkg::SETTLE_CYC
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [31:0]        wb_dat_i,
	input  wire logic [3:0]         wb_sel_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic signed [15:0] azPotIn,
	input  wire logic signed [15:0] azPulseIn,
	input  wire logic signed [15:0] elPotIn,
	input  wire logic signed [15:0] elPulseIn,
	input  wire logic signed [15:0] polPosIn,
	input  wire logic               hiResIn,
	input  wire logic [11:0]        sigIn,
	input  wire logic signed [15:0] pitchIn,
	input  wire logic signed [15:0] rollIn,
	output logic                    azCw,
	output logic                    azCcw,
	output logic                    elUp,
	output logic                    elDn,
	output logic                    polCw,
	output logic                    polCcw,
	output aas_pkg::aas_disp_t      line4
);
	if (SETTLE_CYC < 1) $error("aas_autopeak: SETTLE_CYC must be at least 1");

	typedef enum logic [4:0] {ST_IDLE, ST_JOG, ST_EL, ST_POL, ST_TILT_A, ST_TILT_B, ST_AZ_SEL,
		ST_WAIT, ST_SCAN, ST_SPIRAL, ST_FINE, ST_FIN, ST_DONE} aas_state_t;

	function automatic logic [15:0] stepSize(input logic [7:0] diam, input logic [1:0] band);
		logic [15:0] s;
		s = aas_pkg::BEAM_NUM[band] / ((diam == 8'h00) ? 16'h0001 : {8'h00, diam});
		s = s >> 1;
		return (s == 16'h0000) ? 16'h0001 : s;
	endfunction

	function automatic logic [16:0] absDiff(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		return (d < 0) ? 17'(-d) : 17'(d);
	endfunction

	function automatic aas_pkg::aas_msg_t msgFor(input aas_state_t s, input logic tiltPol);
		case (s)
			ST_TILT_B, ST_AZ_SEL: return aas_pkg::MSG_TILT;
			ST_SCAN:              return aas_pkg::MSG_SCAN;
			ST_SPIRAL:            return aas_pkg::MSG_SPIRAL;
			ST_FINE:              return aas_pkg::MSG_PEAKUP;
			ST_DONE:              return tiltPol ? aas_pkg::MSG_TILT_POL : aas_pkg::MSG_MOVING;
			ST_IDLE, ST_JOG:      return aas_pkg::MSG_IDLE;
			default:              return aas_pkg::MSG_MOVING;
		endcase
	endfunction

	// Sensor synchronisers
	logic signed [15:0] azPot1, azPot2, azPul1, azPul2, elPot1, elPot2, elPul1, elPul2;
	logic signed [15:0] pol1, pol2, pit1, pit2, rol1, rol2;
	logic [11:0]        sig1, sig2;
	logic               hiRes1, hiRes2;

	always_ff @(posedge clk)
	begin
		{azPot1, azPul1, elPot1, elPul1, pol1, pit1, rol1} <=
			{azPotIn, azPulseIn, elPotIn, elPulseIn, polPosIn, pitchIn, rollIn};
		{azPot2, azPul2, elPot2, elPul2, pol2, pit2, rol2} <=
			{azPot1, azPul1, elPot1, elPul1, pol1, pit1, rol1};
		{sig1, hiRes1} <= {sigIn, hiResIn};
		{sig2, hiRes2} <= {sig1, hiRes1};
	end

	// Register bus
	logic [31:0] cfg_ff [aas_pkg::NUM_CFG];
	logic [31:0] nxt_cfg [aas_pkg::NUM_CFG];
	logic [31:0] rd_ff, nxt_rd;
	logic        ack_ff, nxt_ack, wrCfg, startPls, stopPls;
	logic [2:0]  idx;
	logic [31:0] statusWord, dispWord, peakWord, tiltWord;

	always_comb
	begin
		nxt_ack  = wb_cyc_i && wb_stb_i && !ack_ff;
		idx      = wb_adr_i[4:2];
		wrCfg    = nxt_ack && wb_we_i && wb_adr_i[7:5] == 3'h0;
		startPls = wrCfg && idx == 3'h0 && wb_sel_i[0] && wb_dat_i[aas_pkg::CTL_START];
		stopPls  = wrCfg && idx == 3'h0 && wb_sel_i[0] && wb_dat_i[aas_pkg::CTL_STOP];
		for (int i = 0; i < aas_pkg::NUM_CFG; i++)
			nxt_cfg[i] = cfg_ff[i];
		if (wrCfg)
		begin
			for (int b = 0; b < 4; b++)
				if (wb_sel_i[b])
					nxt_cfg[idx][8*b +: 8] = wb_dat_i[8*b +: 8];
			nxt_cfg[0] = nxt_cfg[0] & ~aas_pkg::CTRL_PULSE_MASK;
		end
		nxt_rd = 32'h0000_0000;
		if (nxt_ack && !wb_we_i)
		begin
			if (wb_adr_i[7:5] == 3'h0)
				nxt_rd = cfg_ff[idx];
			else
				case ({wb_adr_i[7:2], 2'b00})
					aas_pkg::REG_STATUS:  nxt_rd = statusWord;
					aas_pkg::REG_DISPLAY: nxt_rd = dispWord;
					aas_pkg::REG_PEAK:    nxt_rd = peakWord;
					aas_pkg::REG_TILT:    nxt_rd = tiltWord;
					default:              nxt_rd = 32'h0000_0000;
				endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_ff <= 1'b0;
			rd_ff  <= 32'h0000_0000;
			for (int i = 0; i < aas_pkg::NUM_CFG; i++)
				cfg_ff[i] <= aas_pkg::RST_CFG[i];
		end
		else
		begin
			ack_ff <= nxt_ack;
			rd_ff  <= nxt_rd;
			for (int i = 0; i < aas_pkg::NUM_CFG; i++)
				cfg_ff[i] <= nxt_cfg[i];
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_ff;

	// Configuration fields
	logic               peakEn, inclined, fineEn, tiltEn, pulseFb, fineOk;
	logic signed [15:0] azTgt, elTgt, polTgt, range, limLo, limHi;
	logic [15:0]        step, jog;
	logic [11:0]        thresh, margin;
	logic signed [15:0] azPos, elPos;

	always_comb
	begin
		peakEn   = cfg_ff[0][aas_pkg::CTL_PEAK_EN];
		inclined = cfg_ff[0][aas_pkg::CTL_INCLINED];
		fineEn   = cfg_ff[0][aas_pkg::CTL_FINE_EN];
		tiltEn   = cfg_ff[0][aas_pkg::CTL_TILT_EN];
		pulseFb  = cfg_ff[0][aas_pkg::CTL_PULSE_FB];
		fineOk   = fineEn && hiRes2;
		azTgt    = signed'(cfg_ff[1][15:0]);
		elTgt    = signed'(cfg_ff[2][15:0]);
		polTgt   = signed'(cfg_ff[3][15:0]);
		range    = signed'(cfg_ff[4][15:0]);
		step     = stepSize(cfg_ff[5][aas_pkg::ANT_DIAM_LSB +: 8],
			cfg_ff[5][aas_pkg::ANT_BAND_LSB +: 2]);
		// 0.3 dB off boresight is about 0.16 beam widths, so 5/16 of a half-beam step
		jog      = (16'(step * 16'h0005) >> 4) | 16'h0001;
		margin   = {4'h0, cfg_ff[5][aas_pkg::ANT_MARGIN_LSB +: 8]};
		thresh   = cfg_ff[6][11:0];
		limLo    = signed'(cfg_ff[7][15:0]);
		limHi    = signed'(cfg_ff[7][aas_pkg::LIM_HI_LSB +: 16]);
		azPos    = (pulseFb && hiRes2) ? azPul2 : azPot2;
		elPos    = (pulseFb && hiRes2) ? elPul2 : elPot2;
	end

	// Sequencer
	aas_state_t         st_ff, nxt_st, ret_ff, nxt_ret;
	logic [31:0]        cnt_ff, nxt_cnt;
	logic signed [15:0] azC_ff, nxt_azC, elC_ff, nxt_elC, polC_ff, nxt_polC;
	logic signed [15:0] bestAz_ff, nxt_bestAz, bestEl_ff, nxt_bestEl, pitch_ff, nxt_pitch;
	logic signed [15:0] roll_ff, nxt_roll, nextAz;
	logic [15:0]        stepN_ff, nxt_stepN, total_ff, nxt_total;
	logic [11:0]        avg_ff, nxt_avg, best_ff, nxt_best;
	logic               found_ff, nxt_found, sNeg_ff, nxt_sNeg, tiltPol_ff, nxt_tiltPol;
	logic [1:0]         dir_ff, nxt_dir;
	logic [3:0]         leg_ff, nxt_leg, legCnt_ff, nxt_legCnt;
	logic [2:0]         fine_ff, nxt_fine;
	logic               goAz, goEl, goPol, busyAz, busyEl, busyPol;
	logic signed [12:0] diff;

	always_comb
	begin
		nxt_st = st_ff;         nxt_ret = ret_ff;         nxt_cnt = cnt_ff;
		nxt_azC = azC_ff;       nxt_elC = elC_ff;         nxt_polC = polC_ff;
		nxt_bestAz = bestAz_ff; nxt_bestEl = bestEl_ff;   nxt_best = best_ff;
		nxt_pitch = pitch_ff;   nxt_roll = roll_ff;       nxt_stepN = stepN_ff;
		nxt_total = total_ff;   nxt_avg = avg_ff;         nxt_found = found_ff;
		nxt_sNeg = sNeg_ff;     nxt_dir = dir_ff;         nxt_leg = leg_ff;
		nxt_legCnt = legCnt_ff; nxt_fine = fine_ff;       nxt_tiltPol = tiltPol_ff;
		goAz = 1'b0;
		goEl = 1'b0;
		goPol = 1'b0;
		diff = 13'(sig2) - 13'(avg_ff);
		nextAz = sNeg_ff ? 16'(azC_ff - signed'(step)) : 16'(azC_ff + signed'(step));
		case (st_ff)
			ST_IDLE, ST_JOG:
				if (startPls)
				begin
					nxt_st = ST_EL;
					nxt_tiltPol = 1'b0;
				end
			ST_EL:
			begin
				nxt_elC = elTgt;
				goEl = 1'b1;
				nxt_ret = ST_POL;
				nxt_st = ST_WAIT;
			end
			ST_POL:
			begin
				nxt_polC = polTgt;
				goPol = 1'b1;
				nxt_ret = tiltEn ? ST_TILT_A : ST_AZ_SEL;
				nxt_st = ST_WAIT;
			end
			ST_TILT_A:
			begin
				nxt_azC = 16'(azTgt + aas_pkg::TILT_FIRST);
				goAz = 1'b1;
				nxt_ret = ST_TILT_B;
				nxt_st = ST_WAIT;
			end
			ST_TILT_B:
			begin
				nxt_pitch = pit2;
				nxt_azC = 16'(azTgt + aas_pkg::TILT_SECOND);
				goAz = 1'b1;
				nxt_ret = ST_AZ_SEL;
				nxt_st = ST_WAIT;
			end
			ST_AZ_SEL:
			begin
				if (tiltEn)
					nxt_roll = rol2;
				nxt_st = ST_WAIT;
				nxt_found = 1'b0;
				nxt_best = 12'h000;
				nxt_bestAz = azTgt;
				nxt_bestEl = elTgt;
				nxt_elC = elTgt;
				goAz = 1'b1;
				goEl = 1'b1;
				if (!peakEn)
				begin
					nxt_azC = azTgt;
					nxt_ret = ST_FIN;
				end
				else if (inclined)
				begin
					nxt_azC = azTgt;
					nxt_ret = ST_SPIRAL;
					nxt_dir = 2'b00;
					nxt_leg = 4'h1;
					nxt_legCnt = 4'h0;
					nxt_stepN = 16'h0000;
				end
				else
				begin
					nxt_sNeg = absDiff(azPos, 16'(azTgt + range)) < absDiff(azPos, 16'(azTgt - range));
					nxt_azC = nxt_sNeg ? 16'(azTgt + range) : 16'(azTgt - range);
					nxt_total = 16'({range, 1'b0} / step);
					nxt_stepN = 16'h0000;
					nxt_avg = 12'h000;
					nxt_ret = ST_SCAN;
				end
			end
			ST_WAIT:
				if (busyAz || busyEl || busyPol)
					nxt_cnt = 32'(SETTLE_CYC);
				else if (cnt_ff != 32'h0000_0000)
					nxt_cnt = cnt_ff - 32'h0000_0001;
				else
					nxt_st = ret_ff;
			ST_SCAN:
			begin
				nxt_avg = (stepN_ff == 16'h0000) ? sig2 : 12'(avg_ff + 12'(diff >>> 3));
				// Signed compare, else a sample under the average reads as a huge rise
				if (stepN_ff != 16'h0000 && diff > signed'({1'b0, margin}) && sig2 > best_ff)
				begin
					nxt_found = 1'b1;
					nxt_best = sig2;
					nxt_bestAz = azC_ff;
				end
				nxt_st = ST_WAIT;
				if (stepN_ff >= total_ff || nextAz > limHi || nextAz < limLo)
				begin
					nxt_azC = nxt_found ? nxt_bestAz : azTgt;
					nxt_elC = elTgt;
					goAz = 1'b1;
					goEl = 1'b1;
					nxt_fine = 3'h0;
					nxt_ret = (nxt_found && fineOk) ? ST_FINE : ST_FIN;
				end
				else
				begin
					nxt_azC = nextAz;
					goAz = 1'b1;
					goEl = stepN_ff % aas_pkg::EL_FIX_EVERY == aas_pkg::EL_FIX_EVERY - 16'h0001;
					nxt_stepN = stepN_ff + 16'h0001;
					nxt_ret = ST_SCAN;
				end
			end
			ST_SPIRAL:
			begin
				nxt_st = ST_WAIT;
				if (sig2 > thresh)
				begin
					nxt_found = 1'b1;
					nxt_bestAz = azC_ff;
					nxt_bestEl = elC_ff;
					nxt_st = ST_FIN;
				end
				else if (leg_ff > aas_pkg::SPIRAL_MAX_LEG)
				begin
					nxt_azC = azTgt;
					nxt_elC = elTgt;
					goAz = 1'b1;
					goEl = 1'b1;
					nxt_ret = ST_FIN;
				end
				else
				begin
					case (aas_pkg::aas_dir_t'(dir_ff))
						aas_pkg::DIR_CW:  nxt_azC = 16'(azC_ff + signed'(step));
						aas_pkg::DIR_UP:  nxt_elC = 16'(elC_ff + signed'(step));
						aas_pkg::DIR_CCW: nxt_azC = 16'(azC_ff - signed'(step));
						default:          nxt_elC = 16'(elC_ff - signed'(step));
					endcase
					goAz = !dir_ff[0];
					goEl = dir_ff[0];
					nxt_stepN = stepN_ff + 16'h0001;
					nxt_legCnt = legCnt_ff + 4'h1;
					if (legCnt_ff + 4'h1 == leg_ff)
					begin
						nxt_legCnt = 4'h0;
						nxt_dir = dir_ff + 2'b01;
						if (dir_ff[0])
							nxt_leg = leg_ff + 4'h1;
					end
					nxt_ret = ST_SPIRAL;
				end
			end
			ST_FINE:
			begin
				if (fine_ff != 3'h0 && sig2 > best_ff)
				begin
					nxt_best = sig2;
					nxt_bestAz = azC_ff;
					nxt_bestEl = elC_ff;
				end
				nxt_azC = nxt_bestAz;
				nxt_elC = nxt_bestEl;
				case (fine_ff)
					3'h0: nxt_azC = 16'(nxt_bestAz + signed'(jog));
					3'h1: nxt_azC = 16'(nxt_bestAz - signed'(jog));
					3'h2: nxt_elC = 16'(nxt_bestEl + signed'(jog));
					3'h3: nxt_elC = 16'(nxt_bestEl - signed'(jog));
					default: ;
				endcase
				goAz = 1'b1;
				goEl = 1'b1;
				nxt_fine = fine_ff + 3'h1;
				nxt_ret = (fine_ff == aas_pkg::FINE_JOGS) ? ST_FIN : ST_FINE;
				nxt_st = ST_WAIT;
			end
			ST_FIN:
				if (tiltEn && !tiltPol_ff)
				begin
					// Roll seen across the beam direction skews the feed by the same angle
					nxt_polC = 16'(polTgt - roll_ff);
					goPol = 1'b1;
					nxt_tiltPol = 1'b1;
					nxt_ret = ST_DONE;
					nxt_st = ST_WAIT;
				end
				else
					nxt_st = ST_DONE;
			ST_DONE:
				nxt_st = ST_JOG;
			default:
				nxt_st = ST_IDLE;
		endcase
		if (stopPls)
		begin
			nxt_st = ST_JOG;
			goAz = 1'b0;
			goEl = 1'b0;
			goPol = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_ff <= ST_IDLE;      ret_ff <= ST_IDLE;      cnt_ff <= 32'h0000_0000;
			azC_ff <= 16'sh0000;   elC_ff <= 16'sh0000;    polC_ff <= 16'sh0000;
			bestAz_ff <= 16'sh0000; bestEl_ff <= 16'sh0000; best_ff <= 12'h000;
			pitch_ff <= 16'sh0000; roll_ff <= 16'sh0000;   stepN_ff <= 16'h0000;
			total_ff <= 16'h0000;  avg_ff <= 12'h000;      found_ff <= 1'b0;
			sNeg_ff <= 1'b0;       dir_ff <= 2'b00;        leg_ff <= 4'h1;
			legCnt_ff <= 4'h0;     fine_ff <= 3'h0;        tiltPol_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;       ret_ff <= nxt_ret;      cnt_ff <= nxt_cnt;
			azC_ff <= nxt_azC;     elC_ff <= nxt_elC;      polC_ff <= nxt_polC;
			bestAz_ff <= nxt_bestAz; bestEl_ff <= nxt_bestEl; best_ff <= nxt_best;
			pitch_ff <= nxt_pitch; roll_ff <= nxt_roll;    stepN_ff <= nxt_stepN;
			total_ff <= nxt_total; avg_ff <= nxt_avg;      found_ff <= nxt_found;
			sNeg_ff <= nxt_sNeg;   dir_ff <= nxt_dir;      leg_ff <= nxt_leg;
			legCnt_ff <= nxt_legCnt; fine_ff <= nxt_fine;  tiltPol_ff <= nxt_tiltPol;
		end
	end

	// Axis drives; a stop drops busy at once so the motors halt on the next edge
	aas_axis_move u_az (.clk(clk), .reset(reset), .go(goAz), .halt(stopPls), .target(nxt_azC),
		.position(azPos), .driveFwd(azCw), .driveRev(azCcw), .busy(busyAz));
	aas_axis_move u_el (.clk(clk), .reset(reset), .go(goEl), .halt(stopPls), .target(nxt_elC),
		.position(elPos), .driveFwd(elUp), .driveRev(elDn), .busy(busyEl));
	aas_axis_move u_pol (.clk(clk), .reset(reset), .go(goPol), .halt(stopPls), .target(nxt_polC),
		.position(pol2), .driveFwd(polCw), .driveRev(polCcw), .busy(busyPol));

	// Display line and status words
	aas_pkg::aas_disp_t disp_ff, nxt_disp;
	aas_state_t         shown;

	always_comb
	begin
		shown = (st_ff == ST_WAIT) ? ret_ff : st_ff;
		// Without tilt the pol settle waits on AZ_SEL, which must not claim a tilt message
		nxt_disp.msg = (shown == ST_AZ_SEL && !tiltEn) ? aas_pkg::MSG_MOVING : msgFor(shown, tiltPol_ff);
		nxt_disp.dir = aas_pkg::aas_dir_t'(dir_ff);
		nxt_disp.total = (shown == ST_SCAN) ? total_ff : 16'h0000;
		nxt_disp.step = stepN_ff;
		nxt_disp.showCounts = shown == ST_FINE;
		statusWord = {24'h00_0000, found_ff, st_ff == ST_JOG, tiltPol_ff, 5'(st_ff)};
		dispWord = {disp_ff.step, disp_ff.total};
		peakWord = {bestEl_ff, bestAz_ff};
		tiltWord = {roll_ff, pitch_ff};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			disp_ff <= '{aas_pkg::MSG_IDLE, aas_pkg::DIR_CW, 16'h0000, 16'h0000, 1'b0};
		else
			disp_ff <= nxt_disp;
	end

	assign line4 = disp_ff;
endmodule // aas_autopeak

/* verilog/aas_axis_move.sv */
// Purpose: Closed-loop drive of one axis to a latched target
// Assumes: Position feedback already synchronised to clk
// Notes:   Busy drops once the error is inside the tolerance band
module aas_axis_move #(
	parameter int TOL = aas_pkg::POS_TOL
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               go,
	input  wire logic               halt,
	input  wire logic signed [15:0] target,
	input  wire logic signed [15:0] position,
	output logic                    driveFwd,
	output logic                    driveRev,
	output logic                    busy
);
	if (TOL < 0) $error("aas_axis_move: TOL must not be negative");

	logic               busy_ff, nxt_busy, fwd_ff, nxt_fwd, rev_ff, nxt_rev;
	logic signed [15:0] tgt_ff, nxt_tgt;
	logic signed [16:0] err;

	always_comb
	begin
		err      = 17'(tgt_ff) - 17'(position);
		nxt_busy = busy_ff;
		nxt_tgt  = tgt_ff;
		if (halt)
			nxt_busy = 1'b0;
		else if (go)
		begin
			nxt_busy = 1'b1;
			nxt_tgt  = target;
		end
		else if (busy_ff && err <= 17'(TOL) && err >= -17'(TOL))
			nxt_busy = 1'b0;
		nxt_fwd = nxt_busy && !go && err > 17'(TOL);
		nxt_rev = nxt_busy && !go && err < -17'(TOL);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			busy_ff <= 1'b0;
			tgt_ff  <= 16'sh0000;
			fwd_ff  <= 1'b0;
			rev_ff  <= 1'b0;
		end
		else
		begin
			busy_ff <= nxt_busy;
			tgt_ff  <= nxt_tgt;
			fwd_ff  <= nxt_fwd;
			rev_ff  <= nxt_rev;
		end
	end

	assign driveFwd = fwd_ff;
	assign driveRev = rev_ff;
	assign busy     = busy_ff;
endmodule // aas_axis_move

/* verilog/aas_pkg.sv */
// Purpose: Shared constants and types for the antenna autopeak sequencer
// Assumes: Angles are signed 16-bit in 0.1 degree units; 200 MHz clock
// Notes:   Writable registers sit at word index 0..7, status words above them
package aas_pkg;
	localparam int CLK_MHZ  = 200;
	localparam int SETTLE_US = 20000;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_AZ_TGT  = 8'h04;
	localparam logic [7:0] REG_EL_TGT  = 8'h08;
	localparam logic [7:0] REG_POL_TGT = 8'h0c;
	localparam logic [7:0] REG_RANGE   = 8'h10;
	localparam logic [7:0] REG_ANT     = 8'h14;
	localparam logic [7:0] REG_THRESH  = 8'h18;
	localparam logic [7:0] REG_LIMIT   = 8'h1c;
	localparam logic [7:0] REG_STATUS  = 8'h20;
	localparam logic [7:0] REG_DISPLAY = 8'h24;
	localparam logic [7:0] REG_PEAK    = 8'h28;
	localparam logic [7:0] REG_TILT    = 8'h2c;
	localparam int NUM_CFG = 8;
	// Control bits
	localparam int CTL_START    = 0;
	localparam int CTL_STOP     = 1;
	localparam int CTL_PEAK_EN  = 2;
	localparam int CTL_INCLINED = 3;
	localparam int CTL_FINE_EN  = 4;
	localparam int CTL_TILT_EN  = 5;
	localparam int CTL_PULSE_FB = 6;
	localparam logic [31:0] CTRL_PULSE_MASK = 32'h0000_0003;
	// Field positions of the antenna and limit words
	localparam int ANT_DIAM_LSB   = 0;
	localparam int ANT_BAND_LSB   = 8;
	localparam int ANT_MARGIN_LSB = 16;
	localparam int LIM_HI_LSB     = 16;
	// Reset values, indexed like the writable registers
	localparam logic [31:0] RST_CFG [NUM_CFG] = '{
		32'h0000_0000, 32'h0000_0000, 32'h0000_0190, 32'h0000_0000,
		32'h0000_0032, 32'h0010_010a, 32'h0000_0400, 32'h0708_f8f8};
	// Beam width numerators per band (C, Ku, Ka, L), 0.1 deg times decimetres
	localparam logic [15:0] BEAM_NUM [4] = '{16'h020d, 16'h00af, 16'h004b, 16'h0578};
	localparam logic signed [15:0] TILT_FIRST  = 16'sh0384;
	localparam logic signed [15:0] TILT_SECOND = 16'sh01c2;
	localparam logic [15:0] EL_FIX_EVERY = 16'h0004;
	localparam logic [3:0]  SPIRAL_MAX_LEG = 4'h8;
	localparam logic [2:0]  FINE_JOGS = 3'h4;
	localparam int POS_TOL = 1;
	typedef enum logic [2:0] {MSG_IDLE, MSG_MOVING, MSG_SCAN, MSG_SPIRAL, MSG_PEAKUP,
		MSG_TILT, MSG_TILT_POL} aas_msg_t;
	typedef enum logic [1:0] {DIR_CW, DIR_UP, DIR_CCW, DIR_DN} aas_dir_t;
	typedef struct packed {
		aas_msg_t    msg;
		aas_dir_t    dir;
		logic [15:0] total;
		logic [15:0] step;
		logic        showCounts;
	} aas_disp_t;
endpackage
